// [inc/lfwr_pkg.sv]
// Notes on behaviour
// - Preamble valid after 192 unbroken carrier periods.
// - Filtered-away dropouts do not restart count.
// - After preamble, regulate gain, settle 512 periods.
// - First gap after preamble starts data.
// - Above target two periods: gain down.
// - Eight periods below target: gain up.
// - Listen mode: regulation off, gain maximum.
// - Demodulator gives 1 below half level.
// - Smoothing bridges dropouts, rejects gap glitches.
// - Smoothing delays each edge 3 to 6.
// - One filtered signal feeds preamble, wake and data; gain uses unfiltered level.
// - Data output disabled until wake event.
// - Enabled data: 1 carrier, 0 gap.
// - Data passed through without decoding.
// - First gap: wake low, data enabled together.
// - Wake stays low until reset.
// - Any reset clears counters, enters listen.
// - Supply-low indication holds whole circuit reset.
// - Only reset leaves the active state.
// - External reset high holds power-down.
// - Listen mode drives data and wake high.
package lfwr_pkg;

  localparam int PREAMBLE_PERIODS = 192;
  localparam int SETTLE_PERIODS = 512;
  localparam int TX_PREAMBLE_MIN = 704;
  localparam int DOWN_PERIODS = 2;
  localparam int UP_PERIODS = 8;
  localparam int FILT_TOP = 4;
  localparam int FILT_DELAY_MIN = 3;
  localparam int FILT_DELAY_MAX = 6;

  localparam int PRE_W = 8;
  localparam int SETTLE_W = 10;
  localparam int FILT_W = 3;
  localparam int DOWN_W = 2;
  localparam int UP_W = 4;
  localparam int RUN_W = 3;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PREAMBLE_PERIODS - 1);
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_PERIODS - 1);
  localparam logic [FILT_W-1:0] FILT_FULL = FILT_W'(FILT_TOP);
  localparam logic [DOWN_W-1:0] DOWN_LAST = DOWN_W'(DOWN_PERIODS - 1);
  localparam logic [UP_W-1:0] UP_LAST = UP_W'(UP_PERIODS - 1);
  localparam logic [RUN_W-1:0] RUN_LO = RUN_W'(FILT_DELAY_MIN);
  localparam logic [RUN_W-1:0] RUN_HI = RUN_W'(FILT_DELAY_MAX);

  typedef enum logic [1:0] {
    LFWR_LISTEN,
    LFWR_REGULATE,
    LFWR_AWAKE
  } lfwr_state_t;

  typedef struct packed {
    logic period_ref;
    logic above_half;
    logic above_target;
    logic ext_reset;
    logic supply_low;
  } lfwr_pins_t;

endpackage

// [hdl/lfwr_top.sv]
`timescale 1ns/1ps
module lfwr_top #(
  parameter int GAIN_W = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire lfwr_pkg::lfwr_pins_t pins,
  output logic host_wake_low,
  output logic data_out,
  output logic [GAIN_W-1:0] gain,
  output logic agc_active,
  output logic agc_settled,
  output logic power_down
);
  import lfwr_pkg::*;

  localparam logic [GAIN_W-1:0] GAIN_MAX = '1;
  localparam logic [GAIN_W-1:0] GAIN_MIN = '0;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  lfwr_pins_t sync1;
  lfwr_pins_t sync2;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  // Either reset source holds every register below except prd_q, power_down and gap_run at its idle value.
  wire hold_rst = sync2.ext_reset | sync2.supply_low;

  // ---------------------------------------------------------------
  // Carrier period sampling
  // ---------------------------------------------------------------
  logic prd_q;
  logic seen_half;
  logic seen_tgt;
  logic ptick;
  logic period_gap;
  logic period_over;

  wire tick = sync2.period_ref & ~prd_q;
  wire half_now = seen_half | sync2.above_half;
  wire tgt_now = seen_tgt | sync2.above_target;
  // Any crossing within a period counts, which bridges half-wave spaces.
  wire demod_gap = ~half_now;
  wire next_seen_half = ~tick & half_now;
  wire next_seen_tgt = ~tick & tgt_now;
  wire next_period_gap = tick ? demod_gap : period_gap;
  wire next_period_over = tick ? tgt_now : period_over;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prd_q <= 1'b0;
      seen_half <= 1'b0;
      seen_tgt <= 1'b0;
      ptick <= 1'b0;
      period_gap <= 1'b1;
      period_over <= 1'b0;
    end else begin
      prd_q <= sync2.period_ref;
      seen_half <= next_seen_half & ~hold_rst;
      seen_tgt <= next_seen_tgt & ~hold_rst;
      ptick <= tick & ~hold_rst;
      period_gap <= next_period_gap | hold_rst;
      period_over <= next_period_over & ~hold_rst;
    end
  end

  // ---------------------------------------------------------------
  // Smoothing filter
  // ---------------------------------------------------------------
  // A run counter: the output flips only after FILT_TOP periods in a row
  // disagree with it, so short dropouts and gap glitches die and every
  // edge is delayed by the same number of periods.
  logic [FILT_W-1:0] filt_cnt;
  logic filt_carrier;
  logic ftick;

  wire filt_opposite = period_gap == filt_carrier;
  wire filt_flip = ptick & filt_opposite & (filt_cnt == FILT_FULL - FILT_W'(1));
  wire [FILT_W-1:0] filt_step = (!filt_opposite | filt_flip) ? '0
    : filt_cnt + FILT_W'(1);
  wire [FILT_W-1:0] next_filt_cnt = ptick ? filt_step : filt_cnt;
  wire next_filt_carrier = filt_flip ? ~filt_carrier : filt_carrier;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      filt_cnt <= '0;
      filt_carrier <= 1'b0;
      ftick <= 1'b0;
    end else if (hold_rst) begin
      filt_cnt <= '0;
      filt_carrier <= 1'b0;
      ftick <= 1'b0;
    end else begin
      filt_cnt <= next_filt_cnt;
      filt_carrier <= next_filt_carrier;
      ftick <= ptick;
    end
  end

  // ---------------------------------------------------------------
  // Preamble detection and mode control
  // ---------------------------------------------------------------
  // Mode control and the data output look only at filt_carrier; gain regulation reads the unfiltered period_over.
  lfwr_state_t state;
  logic [PRE_W-1:0] pre_cnt;

  wire listen = state == LFWR_LISTEN;
  wire pre_done = ftick & filt_carrier & (pre_cnt == PRE_LAST);
  wire start_gap = ftick & ~filt_carrier;
  wire [PRE_W-1:0] next_pre_cnt = !(listen & ftick) ? pre_cnt
    : !filt_carrier ? '0 : pre_cnt + PRE_W'(1);

  lfwr_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      LFWR_LISTEN: begin
        if (pre_done) begin
          next_state = LFWR_REGULATE;
        end
      end
      LFWR_REGULATE: begin
        if (start_gap) begin
          next_state = LFWR_AWAKE;
        end
      end
      LFWR_AWAKE: begin
        next_state = LFWR_AWAKE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Gain regulation
  // ---------------------------------------------------------------
  logic [GAIN_W-1:0] gain_q;
  logic [DOWN_W-1:0] over_cnt;
  logic [UP_W-1:0] under_cnt;
  logic [SETTLE_W-1:0] settle_cnt;
  logic settled;

  wire agc_on = ~listen;
  wire agc_tick = agc_on & ftick;
  wire want_down = agc_tick & period_over & (over_cnt == DOWN_LAST);
  wire want_up = agc_tick & ~period_over & (under_cnt == UP_LAST);
  wire [GAIN_W-1:0] next_gain = !agc_on ? GAIN_MAX
    : (want_down & gain_q != GAIN_MIN) ? gain_q - GAIN_W'(1)
    : (want_up & gain_q != GAIN_MAX) ? gain_q + GAIN_W'(1)
    : gain_q;
  wire [DOWN_W-1:0] next_over_cnt = !agc_tick ? over_cnt
    : (!period_over | want_down) ? '0 : over_cnt + DOWN_W'(1);
  wire [UP_W-1:0] next_under_cnt = !agc_tick ? under_cnt
    : (period_over | want_up) ? '0 : under_cnt + UP_W'(1);
  wire settle_end = agc_tick & (settle_cnt == SETTLE_LAST);
  wire [SETTLE_W-1:0] next_settle_cnt = (agc_tick & ~settled)
    ? settle_cnt + SETTLE_W'(1) : settle_cnt;
  wire next_settled = settled | settle_end;

  // ---------------------------------------------------------------
  // Registered state
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= LFWR_LISTEN;
      pre_cnt <= '0;
      gain_q <= GAIN_MAX;
      over_cnt <= '0;
      under_cnt <= '0;
      settle_cnt <= '0;
      settled <= 1'b0;
    end else if (hold_rst) begin
      state <= LFWR_LISTEN;
      pre_cnt <= '0;
      gain_q <= GAIN_MAX;
      over_cnt <= '0;
      under_cnt <= '0;
      settle_cnt <= '0;
      settled <= 1'b0;
    end else begin
      state <= next_state;
      pre_cnt <= next_pre_cnt;
      gain_q <= next_gain;
      over_cnt <= next_over_cnt;
      under_cnt <= next_under_cnt;
      settle_cnt <= next_settle_cnt;
      settled <= next_settled;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  wire awake_next = ~hold_rst & (next_state == LFWR_AWAKE);
  wire next_wake_low = ~awake_next;
  // The envelope is passed raw once enabled; no decoding is done.
  wire next_data = ~awake_next | next_filt_carrier;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_wake_low <= 1'b1;
      data_out <= 1'b1;
      gain <= GAIN_MAX;
      agc_active <= 1'b0;
      agc_settled <= 1'b0;
      power_down <= 1'b0;
    end else begin
      host_wake_low <= next_wake_low;
      data_out <= next_data;
      gain <= hold_rst ? GAIN_MAX : next_gain;
      agc_active <= ~hold_rst & (next_state != LFWR_LISTEN);
      agc_settled <= ~hold_rst & next_settled;
      power_down <= sync2.ext_reset;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Length of the gap run feeding the filter, used to bound its delay.
  logic [RUN_W-1:0] gap_run;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_run <= '0;
    end else if (ptick) begin
      gap_run <= !period_gap ? '0 : (gap_run == '1) ? gap_run : gap_run + RUN_W'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || hold_rst);

  property p_preamble_len;
    $rose(agc_active) |-> $past(pre_cnt) == PRE_LAST && $past(filt_carrier);
  endproperty
  a_preamble_len: assert property (p_preamble_len) else $error("preamble length wrong");

  property p_gap_restart;
    listen && ftick && !filt_carrier |=> pre_cnt == '0 && !agc_active;
  endproperty
  a_gap_restart: assert property (p_gap_restart) else $error("gap kept count");

  property p_settle;
    $rose(agc_settled) |-> $past(settle_cnt) == SETTLE_LAST && agc_active;
  endproperty
  a_settle: assert property (p_settle) else $error("settle count wrong");

  property p_gain_down;
    want_down && gain_q != GAIN_MIN |=> gain == $past(gain_q) - GAIN_W'(1);
  endproperty
  a_gain_down: assert property (p_gain_down) else $error("gain not lowered");

  property p_gain_up;
    want_up && gain_q != GAIN_MAX |=> gain == $past(gain_q) + GAIN_W'(1);
  endproperty
  a_gain_up: assert property (p_gain_up) else $error("gain not raised");

  property p_listen_idle;
    listen && next_state == LFWR_LISTEN |=> gain == GAIN_MAX && host_wake_low && data_out;
  endproperty
  a_listen_idle: assert property (p_listen_idle) else $error("listen outputs wrong");

  property p_filt_delay;
    $fell(filt_carrier) |-> gap_run >= RUN_LO && gap_run <= RUN_HI;
  endproperty
  a_filt_delay: assert property (p_filt_delay) else $error("filter delay off");

  property p_wake_data;
    $fell(host_wake_low) |-> !data_out && $past(data_out) && agc_active;
  endproperty
  a_wake_data: assert property (p_wake_data) else $error("wake without data");

  property p_wake_hold;
    !host_wake_low |=> !host_wake_low [*2];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake released");

  property p_power_down;
    @(posedge clk) disable iff (!rst_b)
      sync2.ext_reset |=> power_down && host_wake_low && data_out && !agc_active;
  endproperty
  a_power_down: assert property (p_power_down) else $error("not powered down");

  property p_gain_floor;
    want_down && gain_q == GAIN_MIN |=> gain == GAIN_MIN;
  endproperty
  a_gain_floor: assert property (p_gain_floor) else $error("gain wrapped");

  property p_cv_wake;
    $fell(host_wake_low);
  endproperty
  c_wake: cover property (p_cv_wake);

  property p_cv_settle;
    $rose(agc_settled);
  endproperty
  c_settle: cover property (p_cv_settle);

  property p_cv_down;
    want_down;
  endproperty
  c_down: cover property (p_cv_down);

  property p_cv_restart;
    listen && ftick && !filt_carrier && pre_cnt != '0;
  endproperty
  c_restart: cover property (p_cv_restart);

endmodule

// [test/lfwr_host.sv]
`timescale 1ns/1ps
module lfwr_host #(
  parameter int HOLD = 20
) (
  input wire logic clk,
  input wire logic host_wake_low,
  input wire logic do_reset,
  output logic ext_reset,
  output logic seen_wake
);
  // --------------------------------------------------------------
  // Host side
  // --------------------------------------------------------------
  // The host notes a wake and, when told, pulses the reset pin for HOLD clocks.
  initial begin
    ext_reset = 1'b0;
    seen_wake = 1'b0;
    forever begin
      @(negedge clk);
      if (host_wake_low === 1'b0) seen_wake = 1'b1;
      if (do_reset === 1'b1) begin
        ext_reset = 1'b1;
        repeat (HOLD) @(negedge clk);
        ext_reset = 1'b0;
        seen_wake = 1'b0;
      end
    end
  end
endmodule

// [test/lfwr_top_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module lfwr_top_bench;
  import lfwr_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic pref = 1'b0;
  logic ahalf = 1'b0;
  logic atgt = 1'b0;
  logic slow = 1'b0;
  logic do_rst = 1'b0;
  logic host_rst;
  logic seen_wake;
  lfwr_pins_t pins;
  logic host_wake_low;
  logic data_out;
  logic [3:0] gain;
  logic agc_active;
  logic agc_settled;
  logic power_down;
  int n_fail = 0;
  int check_count = 0;
  localparam logic [3:0] GMAX = 4'hf;
  assign pins = '{period_ref: pref, above_half: ahalf, above_target: atgt,
                  ext_reset: host_rst, supply_low: slow};
  lfwr_top lfwr_top_i (.clk(clk), .rst_b(rst_b), .pins(pins),
    .host_wake_low(host_wake_low), .data_out(data_out), .gain(gain),
    .agc_active(agc_active), .agc_settled(agc_settled), .power_down(power_down));
  lfwr_host lfwr_host_i (.clk(clk), .host_wake_low(host_wake_low), .do_reset(do_rst),
    .ext_reset(host_rst), .seen_wake(seen_wake));
  // --------------------------------------------------------------
  // Clocks
  // --------------------------------------------------------------
  // The carrier period is shortened to 16 clocks so the run stays brief.
  initial forever #2 clk = ~clk;
  initial forever begin
    repeat (8) @(negedge clk);
    pref = ~pref;
  end
  task automatic periods(input int n, input logic c, input logic t);
    ahalf = c;
    atgt = t;
    repeat (n) @(posedge pref);
    repeat (8) @(negedge clk);
  endtask
  task automatic listen_chk(input string s);
    `CHK({s, " wake"}, 1'b1, host_wake_low)
    `CHK({s, " data"}, 1'b1, data_out)
    `CHK({s, " gain"}, GMAX, gain)
    `CHK({s, " agc"}, 1'b0, agc_active)
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_pre;
    periods(6, 0, 0);
    periods(150, 1, 1);
    `CHK("early agc", 1'b0, agc_active)
    `CHK("listen gain", GMAX, gain)
    periods(6, 0, 0);
    periods(100, 1, 0);
    periods(2, 0, 0);
    periods(86, 1, 0);
    `CHK("agc before 192", 1'b0, agc_active)
    periods(10, 1, 0);
    `CHK("agc after 192", 1'b1, agc_active)
    $display("t_pre done");
  endtask
  task automatic t_agc;
    periods(8, 1, 1);
    `CHK("gain four down", 1'b1, gain >= 4'ha && gain <= 4'hc)
    `CHK("early settle", 1'b0, agc_settled)
    periods(40, 1, 1);
    `CHK("gain floor", 4'h0, gain)
    periods(160, 1, 0);
    `CHK("gain ceiling", GMAX, gain)
    periods(400, 1, 0);
    `CHK("settled", 1'b1, agc_settled)
    `CHK("no gap wake", 1'b1, host_wake_low)
    `CHK("data off", 1'b1, data_out)
    $display("t_agc done");
  endtask
  task automatic t_wake;
    periods(2, 0, 0);
    `CHK("filter delay", 1'b1, data_out)
    periods(5, 0, 0);
    `CHK("wake low", 1'b0, host_wake_low)
    `CHK("gap data", 1'b0, data_out)
    periods(1, 1, 0);
    periods(3, 0, 0);
    `CHK("gap glitch", 1'b0, data_out)
    periods(6, 1, 0);
    `CHK("carrier data", 1'b1, data_out)
    `CHK("wake held", 1'b0, host_wake_low)
    periods(6, 0, 0);
    `CHK("second gap", 1'b0, data_out)
    periods(50, 1, 0);
    `CHK("stay awake", 1'b0, host_wake_low)
    $display("t_wake done");
  endtask
  task automatic t_ext;
    do_rst = 1'b1;
    repeat (2) @(negedge clk);
    do_rst = 1'b0;
    repeat (10) @(negedge clk);
    `CHK("power down", 1'b1, power_down)
    listen_chk("pin reset");
    repeat (20) @(negedge clk);
    `CHK("power up", 1'b0, power_down)
    periods(6, 0, 0);
    periods(200, 1, 0);
    periods(6, 0, 0);
    `CHK("rewake", 1'b0, host_wake_low)
    `CHK("host saw wake", 1'b1, seen_wake)
    $display("t_ext done");
  endtask
  task automatic t_por;
    slow = 1'b1;
    repeat (10) @(negedge clk);
    listen_chk("supply low");
    `CHK("supply low pd", 1'b0, power_down)
    slow = 1'b0;
    repeat (4) @(negedge clk);
    periods(100, 1, 0);
    periods(6, 0, 0);
    `CHK("count cleared", 1'b1, host_wake_low)
    $display("t_por done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    listen_chk("reset");
    t_pre();
    t_agc();
    t_wake();
    t_ext();
    t_por();
    wrap_up();
  end
  initial begin
    #300000;
    n_fail++;
    wrap_up();
  end
endmodule
